// File: pkg/fr_defines.vh
/*
 Constants of the frequency reference raise/lower/trim block: register
 byte offsets, reset values, limits, function codes and bit positions.
 Assumes inclusion by bare name from the design files.
*/
`ifndef FR_DEFINES_VH
`define FR_DEFINES_VH

// Register byte offsets
`define FR_ADR_CTRL 8'h00
`define FR_ADR_UPPER 8'h04
`define FR_ADR_LOWER 8'h08
`define FR_ADR_MLOWER 8'h0c
`define FR_ADR_TRIM 8'h10
`define FR_ADR_ACCEL 8'h14
`define FR_ADR_DECEL 8'h18
`define FR_ADR_STATUS 8'h1c
`define FR_ADR_FREQ 8'h20
`define FR_ADR_STORED 8'h24
`define FR_ADR_FSEL_BASE 8'h40
`define FR_ADR_FSEL_END 8'h68

// Widths and counts
`define FR_PCT_W 11
`define FR_NUM_TERM 10
`define FR_TERM_IDX_W 4

// Reset values, limits in units of 0.1 percent of maximum output frequency, trim in percent
`define FR_RST_UPPER 11'h3e8
`define FR_RST_LOWER 11'h000
`define FR_RST_MLOWER 11'h000
`define FR_RST_TRIM 7'h0a
`define FR_RST_PERIOD 16'h0100
`define FR_RST_FSEL 8'h00
`define FR_RST_RETAIN 1'b0
`define FR_RST_RUNSRC 2'h1

// Setting ranges
`define FR_PCT_MAX 11'h44c
`define FR_TRIM_MAX 7'h64
`define FR_TRIM_SCALE 11'h00a

// Multi-function input codes
`define FR_FN_HOLD 8'h0a
`define FR_FN_UP 8'h10
`define FR_FN_DOWN 8'h11
`define FR_FN_TINC 8'h1c
`define FR_FN_TDEC 8'h1d

// Control register fields
`define FR_CTRL_RETAIN 0
`define FR_CTRL_RUNSRC_LO 1
`define FR_CTRL_RUNSRC_HI 2

// Status register fields
`define FR_ST_ERR 0
`define FR_ST_RUN 1
`define FR_ST_AGREE 2
`define FR_ST_UD 3
`define FR_ST_HOLD 4

`endif

// File: logic/fr_ramp.v
/*
 Ramp generator: moves the output frequency one step toward the target
 each time the accel or decel period has elapsed.
 Assumes one clock, synchronous active high reset.
*/
`timescale 1ns/1ps
`include "fr_defines.vh"

module fr_ramp (
    input wire mclk_in,
    input wire rst_in,
    input wire [`FR_PCT_W-1:0] target_in,
    input wire hold_in,
    input wire load_in,
    input wire [`FR_PCT_W-1:0] load_val_in,
    input wire [15:0] accel_period_in,
    input wire [15:0] decel_period_in,
    output reg [`FR_PCT_W-1:0] freq_out,
    output wire ramping_out
);

    reg [15:0] cnt;
    wire go_up;
    wire go_dn;
    wire [15:0] period;
    wire step_now;

    assign go_up = target_in > freq_out;
    assign go_dn = target_in < freq_out;
    assign period = go_up ? accel_period_in : decel_period_in;
    assign step_now = (cnt + 16'h0001) >= period;
    assign ramping_out = (go_up | go_dn) & ~hold_in;

    always @(posedge mclk_in) begin
        if (rst_in) begin
            freq_out <= {`FR_PCT_W{1'b0}};
            cnt <= 16'h0000;
        end else if (load_in) begin
            freq_out <= load_val_in; // R4
            cnt <= 16'h0000;
        end else if (hold_in || !(go_up || go_dn)) begin
            cnt <= 16'h0000; // R1
        end else if (step_now) begin
            cnt <= 16'h0000;
            if (go_up) begin
                freq_out <= freq_out + 11'h001; // R7
            end else begin
                freq_out <= freq_out - 11'h001; // R7
            end
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

endmodule

// File: logic/fr_updown_trim.v
/*
 Frequency reference modifier driven by multi-function contact inputs:
 ramp hold with retention, raise/lower with limits, trim increase and
 decrease, configuration error check, classic Wishbone register slave.
 Assumes terminal and run inputs synchronous to mclk_in, and external
 non-volatile storage that presents its word on nv_data_in at reset.
*/
`timescale 1ns/1ps
`include "fr_defines.vh"

// What this block does
// R1: Ramp hold input on freezes ramping at present frequency; off resumes.
// R2: Retention set to 1 keeps the held frequency in non-volatile storage.
// R3: Operator gives run with ramp hold on to resume at retained frequency.
// R4: Retention 0 and run with ramp hold on forces output to zero.
// R5: Function code 10 is raise, code 11 is lower.
// R6: Raise and lower must be assigned to two separate terminals as a pair.
// R7: Raising and lowering follow the configured accel and decel rates.
// R8: Run source should be the control terminals when raise/lower is used; run_src is only stored, never checked, and run always comes from run_in.
// R9: Only one of raise or lower assigned flags the configuration error.
// R10: Raise/lower together with ramp hold assigned flags the error.
// R11: Upper limit 0.0 to 110.0 percent, default 100.0, locked while running.
// R12: Raise/lower frequency is clamped between upper and effective lower limit.
// R13: Effective lower limit is max of analog input and two lower settings.
// R14: Run with raise/lower active accelerates up to the effective lower limit.
// R15: Multi-step speed selection is ignored while raise/lower is in use.
// R16: Retention stores raise/lower reference; run after power-up returns to it.
// R17: Raise or lower turning on during run resets the stored value to zero; the code does so only with retention set to 1.
// R18: Frequency agree is on while running and not accelerating or decelerating.
// R19: Code 1C is trim increase, 1D trim decrease; both assigned together.
// R20: Trim amount 0 to 100 percent, default 10, locked while running.
// R21: Trim increase alone adds, decrease alone subtracts, else unchanged.
// R22: Raise and lower both or neither hold; one alone ramps up or down.
module fr_updown_trim (
    input wire mclk_in,
    input wire rst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire [`FR_NUM_TERM-1:0] term_in,
    input wire run_in,
    input wire [`FR_PCT_W-1:0] analog_ref_in,
    input wire [`FR_PCT_W-1:0] multistep_ref_in,
    input wire multistep_sel_in,
    input wire [`FR_PCT_W-1:0] nv_data_in,
    output wire [`FR_PCT_W-1:0] freq_out,
    output reg agree_out,
    output reg config_error_out,
    output reg [`FR_PCT_W-1:0] nv_data_out,
    output reg nv_write_out
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function [31:0] fr_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer b;
        begin
            fr_merge = old_val;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    fr_merge[b*8 +: 8] = new_val[b*8 +: 8];
                end
            end
        end
    endfunction

    function [`FR_PCT_W-1:0] fr_max;
        input [`FR_PCT_W-1:0] a;
        input [`FR_PCT_W-1:0] b;
        begin
            fr_max = (a > b) ? a : b;
        end
    endfunction

    function [`FR_PCT_W-1:0] fr_clamp;
        input [`FR_PCT_W-1:0] v;
        input [`FR_PCT_W-1:0] lo;
        input [`FR_PCT_W-1:0] hi;
        begin
            fr_clamp = (v < lo) ? lo : v;
            if (fr_clamp > hi) begin
                fr_clamp = hi;
            end
        end
    endfunction

    function fr_alone;
        input a;
        input b;
        begin
            fr_alone = a & ~b;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg retain;
    reg [1:0] run_src;
    reg [`FR_PCT_W-1:0] upper;
    reg [`FR_PCT_W-1:0] lower;
    reg [`FR_PCT_W-1:0] mlower;
    reg [6:0] trim_amt;
    reg [15:0] accel_period;
    reg [15:0] decel_period;
    reg [7:0] func_sel [0:`FR_NUM_TERM-1];
    reg [`FR_PCT_W-1:0] stored;
    reg nv_loaded;
    reg [`FR_PCT_W-1:0] ud_ref;
    reg ud_moving;
    reg run_q;
    reg up_q;
    reg down_q;
    reg [31:0] rd_data;

    wire [`FR_NUM_TERM-1:0] m_up;
    wire [`FR_NUM_TERM-1:0] m_down;
    wire [`FR_NUM_TERM-1:0] m_hold;
    wire [`FR_NUM_TERM-1:0] m_tinc;
    wire [`FR_NUM_TERM-1:0] m_tdec;

    genvar gi;
    generate
        for (gi = 0; gi < `FR_NUM_TERM; gi = gi + 1) begin : g_term
            assign m_up[gi] = func_sel[gi] == `FR_FN_UP; // R5
            assign m_down[gi] = func_sel[gi] == `FR_FN_DOWN; // R5
            assign m_hold[gi] = func_sel[gi] == `FR_FN_HOLD;
            assign m_tinc[gi] = func_sel[gi] == `FR_FN_TINC; // R19
            assign m_tdec[gi] = func_sel[gi] == `FR_FN_TDEC; // R19
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and error check
    wire up_asg = |m_up;
    wire down_asg = |m_down;
    wire hold_asg = |m_hold;
    wire tinc_asg = |m_tinc;
    wire tdec_asg = |m_tdec;
    wire up_on = |(m_up & term_in);
    wire down_on = |(m_down & term_in);
    wire hold_on = |(m_hold & term_in);
    wire tinc_on = |(m_tinc & term_in);
    wire tdec_on = |(m_tdec & term_in);

    wire err_pair = up_asg ^ down_asg; // R9
    wire err_mix = (up_asg | down_asg) & hold_asg; // R10
    wire err_trim = tinc_asg ^ tdec_asg; // R19
    wire cfg_err = err_pair | err_mix | err_trim;

    wire mode_ud = up_asg & down_asg;
    wire mode_hold = hold_asg & ~mode_ud;
    wire run_ok = run_in & ~cfg_err;
    wire run_rise = run_ok & ~run_q;
    wire up_alone = fr_alone(up_on, down_on); // R22
    wire down_alone = fr_alone(down_on, up_on); // R22
    wire ud_rise = (up_on & ~up_q) | (down_on & ~down_q);
    wire ramping;
    wire busy = run_ok | (freq_out != {`FR_PCT_W{1'b0}});

    ////////////////////////////////////////////////////////////////////////
    // Reference path
    wire [`FR_PCT_W-1:0] lower_eff;
    assign lower_eff = fr_max(analog_ref_in, fr_max(lower, mlower)); // R13

    wire [`FR_PCT_W-1:0] trim_scaled = trim_amt * `FR_TRIM_SCALE;
    wire [`FR_PCT_W-1:0] base_ref = multistep_sel_in ? multistep_ref_in :
                                    analog_ref_in;
    wire [11:0] trim_sum = {1'b0, base_ref} + {1'b0, trim_scaled};
    reg [`FR_PCT_W-1:0] trimmed;
    reg [`FR_PCT_W-1:0] target;

    always @* begin
        trimmed = base_ref;
        if (fr_alone(tinc_on, tdec_on)) begin
            trimmed = trim_sum[11] ? `FR_PCT_MAX : trim_sum[10:0]; // R21
        end else if (fr_alone(tdec_on, tinc_on)) begin
            trimmed = (base_ref > trim_scaled) ?
                      base_ref - trim_scaled : {`FR_PCT_W{1'b0}}; // R21
        end
    end

    always @* begin
        if (!run_ok) begin
            target = {`FR_PCT_W{1'b0}};
        end else if (mode_ud) begin
            target = fr_clamp(ud_ref, lower_eff, upper); // R12 R15
        end else begin
            target = fr_clamp(trimmed, lower, upper);
        end
    end

    wire do_load = run_rise & mode_hold & hold_on;
    wire [`FR_PCT_W-1:0] load_val = retain ? stored :
                                    {`FR_PCT_W{1'b0}}; // R4

    fr_ramp u_ramp (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .target_in(target),
        .hold_in(mode_hold & hold_on), // R1
        .load_in(do_load),
        .load_val_in(load_val),
        .accel_period_in(accel_period),
        .decel_period_in(decel_period),
        .freq_out(freq_out),
        .ramping_out(ramping)
    );

    ////////////////////////////////////////////////////////////////////////
    // Raise/lower reference, retention and status
    always @(posedge mclk_in) begin
        if (rst_in) begin
            ud_ref <= {`FR_PCT_W{1'b0}};
            ud_moving <= 1'b0;
            run_q <= 1'b0;
            up_q <= 1'b0;
            down_q <= 1'b0;
            agree_out <= 1'b0;
            config_error_out <= 1'b0;
        end else begin
            run_q <= run_ok;
            up_q <= up_on;
            down_q <= down_on;
            agree_out <= run_ok & ~ramping; // R18
            config_error_out <= cfg_err;
            ud_moving <= run_ok & (up_alone | down_alone);
            if (run_rise) begin
                ud_ref <= retain ? fr_max(stored, lower_eff) :
                          lower_eff; // R14 R16
            end else if (run_ok && up_alone) begin
                ud_ref <= upper; // R22
            end else if (run_ok && down_alone) begin
                ud_ref <= lower_eff; // R22
            end else if (ud_moving) begin
                ud_ref <= freq_out; // R22
            end
        end
    end

    always @(posedge mclk_in) begin
        if (rst_in) begin
            stored <= {`FR_PCT_W{1'b0}};
            nv_loaded <= 1'b0;
            nv_data_out <= {`FR_PCT_W{1'b0}};
            nv_write_out <= 1'b0;
        end else begin
            nv_write_out <= 1'b0;
            nv_data_out <= stored;
            if (!nv_loaded) begin
                stored <= nv_data_in; // R16
                nv_loaded <= 1'b1;
            end else if (retain && mode_ud && run_ok && ud_rise) begin
                stored <= {`FR_PCT_W{1'b0}}; // R17
                nv_write_out <= 1'b1;
            end else if (retain && run_ok && !do_load &&
                         ((mode_hold && hold_on) ||
                          (mode_ud && !up_alone && !down_alone)) &&
                         stored != freq_out && !ramping) begin
                stored <= freq_out; // R2 R16
                nv_write_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire bus_wr = bus_req & wb_we_in;
    wire fsel_hit = (wb_adr_in >= `FR_ADR_FSEL_BASE) &&
                    (wb_adr_in < `FR_ADR_FSEL_END);
    wire [7:0] fsel_off = wb_adr_in - `FR_ADR_FSEL_BASE;
    wire [`FR_TERM_IDX_W-1:0] fsel_idx = fsel_off[5:2];

    always @* begin
        rd_data = 32'h0000_0000;
        if (wb_adr_in == `FR_ADR_CTRL) begin
            rd_data[`FR_CTRL_RETAIN] = retain;
            rd_data[`FR_CTRL_RUNSRC_HI:`FR_CTRL_RUNSRC_LO] = run_src;
        end else if (wb_adr_in == `FR_ADR_UPPER) begin
            rd_data[`FR_PCT_W-1:0] = upper;
        end else if (wb_adr_in == `FR_ADR_LOWER) begin
            rd_data[`FR_PCT_W-1:0] = lower;
        end else if (wb_adr_in == `FR_ADR_MLOWER) begin
            rd_data[`FR_PCT_W-1:0] = mlower;
        end else if (wb_adr_in == `FR_ADR_TRIM) begin
            rd_data[6:0] = trim_amt;
        end else if (wb_adr_in == `FR_ADR_ACCEL) begin
            rd_data[15:0] = accel_period;
        end else if (wb_adr_in == `FR_ADR_DECEL) begin
            rd_data[15:0] = decel_period;
        end else if (wb_adr_in == `FR_ADR_STATUS) begin
            rd_data[`FR_ST_ERR] = cfg_err;
            rd_data[`FR_ST_RUN] = run_ok;
            rd_data[`FR_ST_AGREE] = agree_out;
            rd_data[`FR_ST_UD] = mode_ud; // R15
            rd_data[`FR_ST_HOLD] = mode_hold;
        end else if (wb_adr_in == `FR_ADR_FREQ) begin
            rd_data[`FR_PCT_W-1:0] = freq_out;
        end else if (wb_adr_in == `FR_ADR_STORED) begin
            rd_data[`FR_PCT_W-1:0] = stored;
        end else if (fsel_hit) begin
            rd_data[7:0] = func_sel[fsel_idx];
        end
    end

    wire [31:0] wmerge = fr_merge(rd_data, wb_dat_in, wb_sel_in);

    integer k;
    always @(posedge mclk_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
            retain <= `FR_RST_RETAIN;
            run_src <= `FR_RST_RUNSRC;
            upper <= `FR_RST_UPPER;
            lower <= `FR_RST_LOWER;
            mlower <= `FR_RST_MLOWER;
            trim_amt <= `FR_RST_TRIM;
            accel_period <= `FR_RST_PERIOD;
            decel_period <= `FR_RST_PERIOD;
            for (k = 0; k < `FR_NUM_TERM; k = k + 1) begin
                func_sel[k] <= `FR_RST_FSEL;
            end
        end else begin
            wb_ack_out <= bus_req;
            if (bus_req && !wb_we_in) begin
                wb_dat_out <= rd_data;
            end
            if (bus_wr && !busy) begin
                if (wb_adr_in == `FR_ADR_CTRL) begin
                    retain <= wmerge[`FR_CTRL_RETAIN];
                    run_src <= wmerge[`FR_CTRL_RUNSRC_HI:`FR_CTRL_RUNSRC_LO];
                end else if (wb_adr_in == `FR_ADR_UPPER &&
                             wmerge[31:0] <= {21'h0, `FR_PCT_MAX}) begin
                    upper <= wmerge[`FR_PCT_W-1:0]; // R11
                end else if (wb_adr_in == `FR_ADR_LOWER &&
                             wmerge[31:0] <= {21'h0, `FR_PCT_MAX}) begin
                    lower <= wmerge[`FR_PCT_W-1:0];
                end else if (wb_adr_in == `FR_ADR_MLOWER &&
                             wmerge[31:0] <= {21'h0, `FR_PCT_MAX}) begin
                    mlower <= wmerge[`FR_PCT_W-1:0];
                end else if (wb_adr_in == `FR_ADR_TRIM &&
                             wmerge[31:0] <= {25'h0, `FR_TRIM_MAX}) begin
                    trim_amt <= wmerge[6:0]; // R20
                end else if (fsel_hit) begin
                    func_sel[fsel_idx] <= wmerge[7:0];
                end
            end
            if (bus_wr) begin
                if (wb_adr_in == `FR_ADR_ACCEL) begin
                    accel_period <= wmerge[15:0]; // R7
                end else if (wb_adr_in == `FR_ADR_DECEL) begin
                    decel_period <= wmerge[15:0]; // R7
                end
            end
        end
    end

endmodule

// File: verif/fr_updown_trim_assertions.sv
/* Port checker for fr_updown_trim: bus handshake, ramp steps, agree
   and configuration error timing. Assumes one clock, bound below. */
`timescale 1ns/1ps
`include "fr_defines.vh"
module fr_updown_trim_assertions (
    input wire mclk_in,
    input wire rst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    input wire run_in,
    input wire [`FR_PCT_W-1:0] freq_out,
    input wire agree_out,
    input wire config_error_out,
    input wire nv_write_out
);
default clocking @(posedge mclk_in); endclocking
default disable iff (rst_in);
////////////////////////////////////////
ack_latency_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("ack late");
ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
ack_cause_a: assert property (wb_ack_out |-> $past(wb_stb_in)
    && $past(wb_cyc_in)) else $error("ack without request");
dat_hold_a: assert property (!wb_ack_out |-> $stable(wb_dat_out))
    else $error("read data moved without ack");
agree_run_a: assert property (
    agree_out |-> ($past(run_in) || $past(run_in, 2)))
    else $error("agree without run");
freq_step_a: assert property (
    $past(run_in) && $past(run_in, 2) && $changed(freq_out)
    |-> freq_out == $past(freq_out) + 1 || freq_out + 1 == $past(freq_out))
    else $error("frequency jumped");
stop_rest_a: assert property ((!run_in [*2]) ##0 freq_out == 0
    |=> freq_out == 0) else $error("motion without run");
error_write_a: assert property (
    $changed(config_error_out) |-> wb_ack_out || $past(wb_ack_out))
    else $error("error changed without write");
cover property ($rose(agree_out));
cover property ($rose(config_error_out));
cover property (nv_write_out);
cover property (wb_ack_out);
endmodule
bind fr_updown_trim fr_updown_trim_assertions i_fr_updown_trim_assertions (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out),
    .run_in(run_in),
    .freq_out(freq_out),
    .agree_out(agree_out),
    .config_error_out(config_error_out),
    .nv_write_out(nv_write_out)
);

// File: verif/fr_contacts.sv
/* Contact switch model for the multi-function terminals and run.
   Assumes its tasks are called right after a rising clock edge. */
`timescale 1ns/1ps
`include "fr_defines.vh"
module fr_contacts (
    input wire mclk_in,
    output reg [`FR_NUM_TERM-1:0] term_out,
    output reg run_out
);
////////////////////////////////////////
initial begin
    term_out = 0;
    run_out = 1'b0;
end
// Contacts close after a number of settle clocks
task set_terms(input [`FR_NUM_TERM-1:0] v, input integer dly);
    begin
        repeat (dly) @(posedge mclk_in);
        term_out <= v;
        @(posedge mclk_in);
    end
endtask
// Run closes on the next edge, after any terminal change has landed
task set_run(input v);
    begin
        @(posedge mclk_in);
        run_out <= v;
    end
endtask
endmodule

// File: verif/fr_updown_trim_test.sv
/* Bench for fr_updown_trim: registers, configuration check, raise and
   lower, ramp hold, retention and trim. Assumes contacts and checker. */
`timescale 1ns/1ps
`include "fr_defines.vh"
module fr_updown_trim_test;
reg mclk_in = 1'b0;
reg rst_in = 1'b1;
reg cyc = 1'b0;
reg stb = 1'b0;
reg we = 1'b0;
reg [7:0] adr = 8'h00;
reg [31:0] wdat = 32'h0000_0000;
reg [3:0] sel = 4'hf;
reg [`FR_PCT_W-1:0] analog = 11'h0c8;
reg [`FR_PCT_W-1:0] mref = 11'h000;
reg msel = 1'b0;
reg [`FR_PCT_W-1:0] nv_in = 11'h000;
wire [31:0] rdat;
wire ack;
wire [`FR_NUM_TERM-1:0] term;
wire run;
wire [`FR_PCT_W-1:0] freq;
wire agree;
wire err;
wire [`FR_PCT_W-1:0] nv_out;
wire nvw;
integer n_fail = 0;
integer checks = 0;
integer k;
integer i;
reg [31:0] v;
reg [`FR_PCT_W-1:0] f;
always #4 mclk_in = ~mclk_in;
fr_contacts i_fr_contacts (
    .mclk_in(mclk_in),
    .term_out(term),
    .run_out(run)
);
fr_updown_trim i_fr_updown_trim (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wb_cyc_in(cyc),
    .wb_stb_in(stb),
    .wb_we_in(we),
    .wb_adr_in(adr),
    .wb_sel_in(sel),
    .wb_dat_in(wdat),
    .wb_dat_out(rdat),
    .wb_ack_out(ack),
    .term_in(term),
    .run_in(run),
    .analog_ref_in(analog),
    .multistep_ref_in(mref),
    .multistep_sel_in(msel),
    .nv_data_in(nv_in),
    .freq_out(freq),
    .agree_out(agree),
    .config_error_out(err),
    .nv_data_out(nv_out),
    .nv_write_out(nvw)
);
////////////////////////////////////////
task close_out;
    begin
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    end
endtask
task cmp(input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task tick;
    begin
        i = i + 1;
        if (i > 4000) begin
            n_fail = n_fail + 1;
            close_out;
        end
        @(posedge mclk_in);
    end
endtask
task wb(input w, input [7:0] a, input [31:0] d);
    begin
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        @(posedge mclk_in);
        while (ack !== 1'b1) tick;
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk_in);
    end
endtask
task wr(input [7:0] a, input [31:0] d);
    wb(1'b1, a, d);
endtask
task rd(input [7:0] a, input [31:0] e);
    begin
        wb(1'b0, a, 32'h0000_0000);
        cmp(v, e);
    end
endtask
task settle(input [31:0] e);
    begin
        repeat (4) @(posedge mclk_in);
        i = 0;
        while (agree !== 1'b1) tick;
        cmp({21'h0, freq}, e);
    end
endtask
task halt;
    begin
        i_fr_contacts.set_run(1'b0);
        i = 0;
        while (freq !== 11'h000) tick;
    end
endtask
task rst_pulse;
    begin
        rst_in <= 1'b1;
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
    end
endtask
////////////////////////////////////////
initial begin
    rst_pulse;
    rd(`FR_ADR_CTRL, 32'h0000_0002);
    rd(`FR_ADR_MLOWER, 32'h0000_0000);
    wr(`FR_ADR_UPPER, 32'h0000_044d);
    wr(`FR_ADR_TRIM, 32'h0000_0065);
    rd(`FR_ADR_UPPER, 32'h0000_03e8);
    rd(`FR_ADR_TRIM, 32'h0000_000a);
    wr(8'h30, 32'h0000_1234);
    rd(8'h30, 32'h0000_0000);
    for (k = 0; k < 7; k = k + 1) begin
        case (k)
            0: v = {8'h40, `FR_FN_UP, 1'b1};
            1: v = {8'h44, `FR_FN_DOWN, 1'b0};
            2: v = {8'h48, `FR_FN_HOLD, 1'b1};
            3: v = {8'h48, `FR_FN_TINC, 1'b1};
            4: v = {8'h4c, `FR_FN_TDEC, 1'b0};
            5: v = {8'h4c, 8'h00, 1'b1};
            default: v = {8'h48, 8'h00, 1'b0};
        endcase
        f = {10'h0, v[0]};
        wr(v[16:9], {24'h00_0000, v[8:1]});
        repeat (3) @(posedge mclk_in);
        cmp({31'h0, err}, {21'h0, f});
    end
    sel <= 4'h1;
    wr(`FR_ADR_LOWER, 32'h0000_0564);
    sel <= 4'hf;
    rd(`FR_ADR_LOWER, 32'h0000_0064);
    wr(`FR_ADR_MLOWER, 32'h0000_0050);
    wr(`FR_ADR_UPPER, 32'h0000_012c);
    wr(`FR_ADR_ACCEL, 32'h0000_0001);
    wr(`FR_ADR_DECEL, 32'h0000_0001);
    i_fr_contacts.set_run(1'b1);
    settle(32'h0000_00c8);
    wr(`FR_ADR_UPPER, 32'h0000_03e8);
    rd(`FR_ADR_UPPER, 32'h0000_012c);
    i_fr_contacts.set_terms(10'h001, 3);
    settle(32'h0000_012c);
    i_fr_contacts.set_terms(10'h003, 0);
    repeat (20) @(posedge mclk_in);
    cmp({21'h0, freq}, 32'h0000_012c);
    msel <= 1'b1;
    mref <= 11'h3ff;
    i_fr_contacts.set_terms(10'h002, 0);
    settle(32'h0000_00c8);
    analog <= 11'h032;
    settle(32'h0000_0064);
    i_fr_contacts.set_terms(10'h000, 0);
    repeat (20) @(posedge mclk_in);
    cmp({21'h0, freq}, 32'h0000_0064);
    msel <= 1'b0;
    halt;
    nv_in <= 11'h0fa;
    rst_pulse;
    repeat (2) @(posedge mclk_in);
    cmp({21'h0, nv_out}, 32'h0000_00fa);
    wr(`FR_ADR_FSEL_BASE, 32'h0000_0010);
    wr(8'h44, 32'h0000_0011);
    wr(`FR_ADR_CTRL, 32'h0000_0003);
    wr(`FR_ADR_ACCEL, 32'h0000_0001);
    wr(`FR_ADR_DECEL, 32'h0000_0001);
    i_fr_contacts.set_run(1'b1);
    settle(32'h0000_00fa);
    i_fr_contacts.set_terms(10'h001, 0);
    @(posedge mclk_in);
    cmp({31'h0, nvw}, 32'h0000_0001);
    repeat (2) @(posedge mclk_in);
    cmp({21'h0, nv_out}, 32'h0000_0000);
    settle(32'h0000_03e8);
    i_fr_contacts.set_terms(10'h000, 0);
    repeat (10) @(posedge mclk_in);
    cmp({21'h0, nv_out}, 32'h0000_03e8);
    halt;
    wr(8'h44, 32'h0000_0000);
    wr(`FR_ADR_FSEL_BASE, 32'h0000_000a);
    wr(`FR_ADR_CTRL, 32'h0000_0002);
    i_fr_contacts.set_run(1'b1);
    settle(32'h0000_0032);
    i_fr_contacts.set_terms(10'h001, 0);
    i_fr_contacts.set_run(1'b0);
    i_fr_contacts.set_run(1'b1);
    repeat (10) @(posedge mclk_in);
    cmp({21'h0, freq}, 32'h0000_0000);
    i_fr_contacts.set_terms(10'h000, 2);
    settle(32'h0000_0032);
    wr(`FR_ADR_ACCEL, 32'h0000_0008);
    analog <= 11'h1f4;
    repeat (100) @(posedge mclk_in);
    i_fr_contacts.set_terms(10'h001, 0);
    repeat (3) @(posedge mclk_in);
    f = freq;
    repeat (40) @(posedge mclk_in);
    cmp({21'h0, freq}, {21'h0, f});
    i_fr_contacts.set_terms(10'h000, 0);
    settle(32'h0000_01f4);
    halt;
    wr(`FR_ADR_FSEL_BASE, 32'h0000_001c);
    wr(8'h44, 32'h0000_001d);
    wr(`FR_ADR_ACCEL, 32'h0000_0001);
    analog <= 11'h190;
    i_fr_contacts.set_run(1'b1);
    for (k = 0; k < 4; k = k + 1) begin
        v = k == 1 ? 32'h0000_01f4 : 32'h0000_0190;
        v = k == 2 ? 32'h0000_012c : v;
        i_fr_contacts.set_terms(k[9:0], 1);
        settle(v);
    end
    msel <= 1'b1;
    mref <= 11'h258;
    settle(32'h0000_0258);
    close_out;
end
endmodule
